// File: core/pxc_crossbar.sv
// port crossbar with port 0/1 latches, drive modes and port 1 input modes
`timescale 1ns/1ps
module pxc_crossbar
	import pxc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] sfrAddr,
	input wire logic [7:0] sfrPage,
	input wire logic sfrWe,
	input wire logic [7:0] sfrWdata,
	input wire logic sfrRe,
	output logic [7:0] sfrRdata,
	output logic sfrHit,
	input wire logic bitWe,
	input wire logic [7:0] bitAddr,
	input wire logic bitVal,
	input wire logic spiFourWire,
	input wire logic uartAMode0,
	input wire logic uartBMode0,
	input wire logic [NUM_SIG-1:0] periphOut,
	input wire logic [NUM_SIG-1:0] periphOe,
	output logic [NUM_SIG-1:0] periphIn,
	input wire logic [NUM_PIN-1:0] pinIn,
	output logic [NUM_PIN-1:0] pinOut,
	output logic [NUM_PIN-1:0] pinOe,
	output logic [NUM_PIN-1:0] pullupEn,
	output logic canTxPushPull
);
	logic [7:0] p0Latch_q, p1Latch_q, p0Mode_q, p1Mode_q, p1InMode_q;
	logic [7:0] route0_q, route1_q, route2_q, route3_q;
	logic [7:0] rdata_q;
	logic hit_q;
	logic [NUM_SIG-1:0] periphIn_q, periphIn_d;
	logic [NUM_PIN-1:0] pinOut_q, pinOe_q, pullup_q, pinOut_d, pinOe_d, pullup_d;
	logic [NUM_PIN-1:0] claimed;
	logic [4:0] pinSel [NUM_PIN];
	logic [5:0] sigRank [NUM_SIG];
	logic [4:0] pinRank [NUM_PIN];

	// drive of one pin: {output enable, output value}
	function automatic logic [1:0] pinDrive(input logic v, input logic pushPull);
		pinDrive = pushPull ? {1'b1, v} : {~v, 1'b0};
	endfunction

	function automatic logic isAddr(input logic [7:0] a, input logic [7:0] ref_a);
		isAddr = (a == ref_a);
	endfunction

	// register decode; port data ignores the page
	wire pageCfg = (sfrPage == PAGE_CFG);
	wire wrP0 = sfrWe && isAddr(sfrAddr, ADDR_P0);
	wire wrP1 = sfrWe && isAddr(sfrAddr, ADDR_P1);
	wire wrP0Mode = sfrWe && pageCfg && isAddr(sfrAddr, ADDR_P0MODE);
	wire wrP1Mode = sfrWe && pageCfg && isAddr(sfrAddr, ADDR_P1MODE);
	wire wrP1In = sfrWe && pageCfg && isAddr(sfrAddr, ADDR_P1INMODE);
	wire wrR0 = sfrWe && pageCfg && isAddr(sfrAddr, ADDR_ROUTE0);
	wire wrR1 = sfrWe && pageCfg && isAddr(sfrAddr, ADDR_ROUTE1);
	wire wrR2 = sfrWe && pageCfg && isAddr(sfrAddr, ADDR_ROUTE2);
	wire wrR3 = sfrWe && pageCfg && isAddr(sfrAddr, ADDR_ROUTE3);
	wire bitP0 = bitWe && (bitAddr[7:3] == ADDR_P0[7:3]);
	wire bitP1 = bitWe && (bitAddr[7:3] == ADDR_P1[7:3]);

	// read values come from the pins, not the latches
	wire [7:0] p0Level = pinIn[7:0];
	wire [7:0] p1Level = pinIn[15:8] & p1InMode_q;
	wire [7:0] route2Rd = route2_q & ROUTE2_WMASK;
	wire [7:0] route3Rd = route3_q & ROUTE3_WMASK;
	wire rdCfg = sfrRe && pageCfg;
	wire [8:0] rdSel =
		(sfrRe && isAddr(sfrAddr, ADDR_P0)) ? {1'b1, p0Level} :
		(sfrRe && isAddr(sfrAddr, ADDR_P1)) ? {1'b1, p1Level} :
		(rdCfg && isAddr(sfrAddr, ADDR_P0MODE)) ? {1'b1, p0Mode_q} :
		(rdCfg && isAddr(sfrAddr, ADDR_P1MODE)) ? {1'b1, p1Mode_q} :
		(rdCfg && isAddr(sfrAddr, ADDR_P1INMODE)) ? {1'b1, p1InMode_q} :
		(rdCfg && isAddr(sfrAddr, ADDR_ROUTE0)) ? {1'b1, route0_q} :
		(rdCfg && isAddr(sfrAddr, ADDR_ROUTE1)) ? {1'b1, route1_q} :
		(rdCfg && isAddr(sfrAddr, ADDR_ROUTE2)) ? {1'b1, route2Rd} :
		(rdCfg && isAddr(sfrAddr, ADDR_ROUTE3)) ? {1'b1, route3Rd} :
		9'h000;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			p0Latch_q <= RST_LATCH;
		end else if (bitP0) begin
			p0Latch_q[bitAddr[2:0]] <= bitVal;
		end else if (wrP0) begin
			p0Latch_q <= sfrWdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			p1Latch_q <= RST_LATCH;
		end else if (bitP1) begin
			p1Latch_q[bitAddr[2:0]] <= bitVal;
		end else if (wrP1) begin
			p1Latch_q <= sfrWdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			p0Mode_q <= RST_MODE;
			p1Mode_q <= RST_MODE;
			p1InMode_q <= RST_INMODE;
		end else begin
			if (wrP0Mode) p0Mode_q <= sfrWdata;
			if (wrP1Mode) p1Mode_q <= sfrWdata;
			if (wrP1In) p1InMode_q <= sfrWdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			route0_q <= RST_ROUTE;
			route1_q <= RST_ROUTE;
			route2_q <= RST_ROUTE;
			route3_q <= RST_ROUTE;
		end else begin
			if (wrR0) route0_q <= sfrWdata;
			if (wrR1) route1_q <= sfrWdata;
			if (wrR2) route2_q <= sfrWdata & ROUTE2_WMASK;
			if (wrR3) route3_q <= sfrWdata & ROUTE3_WMASK;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rdata_q <= 8'h00;
			hit_q <= 1'b0;
		end else begin
			rdata_q <= rdSel[7:0];
			hit_q <= rdSel[8];
		end
	end

	// enable vector in priority order
	wire xbarEn = route2_q[B2_XBAR];
	wire [2:0] cexRaw = route0_q[B0_CEX_HI:B0_CEX_LO];
	// code 7 is undefined; treat it as the widest setting
	wire [2:0] cexCnt = (cexRaw > CEX_MAX) ? CEX_MAX : cexRaw;
	wire [5:0] cexEn = ~(6'h3f << cexCnt);
	wire spiEn = route0_q[B0_SPI];
	wire [NUM_SIG-1:0] enRaw = {
		route3_q[B3_CNV], route1_q[7], route2_q[B2_T4EX], route2_q[B2_T4],
		route3_q[B3_T3EX], route3_q[B3_T3], route1_q[6:1],
		route3_q[B3_CP2], route1_q[0], route0_q[B0_CP0], route0_q[B0_ECI],
		cexEn, {2{route2_q[B2_UARTB]}}, {2{route0_q[B0_TWI]}},
		spiEn && spiFourWire, {3{spiEn}}, {2{route0_q[B0_UARTA]}}
	};
	wire [NUM_SIG-1:0] enVec = xbarEn ? enRaw : '0;
	wire [NUM_PIN-1:0] skip = {~p1InMode_q, 8'h00};
	wire [NUM_PIN-1:0] modeAll = {p1Mode_q, p0Mode_q};
	wire [NUM_PIN-1:0] latchAll = {p1Latch_q, p0Latch_q};
	wire [NUM_SIG-1:0] forceOd = ((NUM_SIG'(1) << SIG_SDA) | (NUM_SIG'(1) << SIG_SCL)) |
		(NUM_SIG'(uartAMode0) << SIG_RXA) | (NUM_SIG'(uartBMode0) << SIG_RXB);

	// rank of each signal among enabled ones meets rank of each free pin;
	// signals beyond the sixteenth free pin belong to ports outside this block
	always_comb begin
		logic [5:0] cnt;
		logic [4:0] pc;
		cnt = 6'd0;
		pc = 5'd0;
		periphIn_d = {NUM_SIG{IDLE_IN}};
		for (int s = 0; s < NUM_SIG; s++) begin
			sigRank[s] = cnt;
			cnt = cnt + {5'd0, enVec[s]};
		end
		for (int p = 0; p < NUM_PIN; p++) begin
			pinRank[p] = pc;
			pc = pc + {4'd0, ~skip[p]};
		end
		for (int p = 0; p < NUM_PIN; p++) begin
			claimed[p] = 1'b0;
			pinSel[p] = 5'd0;
			for (int s = 0; s < NUM_SIG; s++) begin
				if (enVec[s] && !skip[p] && sigRank[s] == {1'b0, pinRank[p]}) begin
					claimed[p] = 1'b1;
					pinSel[p] = 5'(s);
					periphIn_d[s] = pinIn[p];
				end
			end
		end
	end

	always_comb begin
		logic [1:0] drv;
		drv = 2'b00;
		for (int p = 0; p < NUM_PIN; p++) begin
			if (!xbarEn) begin
				drv = 2'b00;
			end else if (claimed[p]) begin
				drv = periphOe[pinSel[p]] ?
					pinDrive(periphOut[pinSel[p]], modeAll[p] && !forceOd[pinSel[p]]) :
					2'b00;
			end else begin
				drv = pinDrive(latchAll[p], modeAll[p]);
			end
			pinOe_d[p] = drv[1];
			pinOut_d[p] = drv[0];
			// a pin driving low never fights its own pull-up
			pullup_d[p] = !route2_q[B2_PUDIS] && !skip[p] && !(drv[1] && !drv[0]);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pinOut_q <= '0;
			pinOe_q <= '0;
			pullup_q <= '0;
			periphIn_q <= {NUM_SIG{IDLE_IN}};
		end else begin
			pinOut_q <= pinOut_d;
			pinOe_q <= pinOe_d;
			pullup_q <= pullup_d;
			periphIn_q <= periphIn_d;
		end
	end

	assign sfrRdata = rdata_q;
	assign sfrHit = hit_q;
	assign pinOut = pinOut_q;
	assign pinOe = pinOe_q;
	assign pullupEn = pullup_q;
	assign periphIn = periphIn_q;
	assign canTxPushPull = route3_q[B3_CANPP];

	sequence sqRdP1Analog;
		sfrRe && isAddr(sfrAddr, ADDR_P1) && !p1InMode_q[0];
	endsequence

	sequence sqRdRoute2;
		sfrRe && pageCfg && isAddr(sfrAddr, ADDR_ROUTE2);
	endsequence

	chk_xbar_off_input: assert property (@(posedge clk_sys) disable iff (rst)
		!xbarEn |=> (pinOe_q == '0))
		else $error("pin driven while crossbar disabled");

	chk_route2_reserved: assert property (@(posedge clk_sys) disable iff (rst)
		sqRdRoute2 |=> (sfrRdata[5] == 1'b0) && (sfrRdata[1:0] == 2'b00) && sfrHit)
		else $error("reserved route bits read nonzero");

	chk_p1_analog_read: assert property (@(posedge clk_sys) disable iff (rst)
		sqRdP1Analog |=> !sfrRdata[0])
		else $error("analog pin read nonzero");

	chk_pullup_disable: assert property (@(posedge clk_sys) disable iff (rst)
		route2_q[B2_PUDIS] |=> (pullupEn == '0))
		else $error("pull-up on while globally disabled");

	chk_uart_a_pins: assert property (@(posedge clk_sys) disable iff (rst)
		(xbarEn && route0_q[B0_UARTA]) |=> (periphIn[SIG_RXA] == $past(pinIn[1])))
		else $error("serial A receive not taken from pin 0.1");

	chk_sda_open_drain: assert property (@(posedge clk_sys) disable iff (rst)
		(xbarEn && claimed[0] && pinSel[0] == 5'(SIG_SDA) && periphOe[SIG_SDA]) |=> !pinOut[0])
		else $error("two-wire data pin driven high");

	chk_cex_count: assert property (@(posedge clk_sys) disable iff (rst)
		(xbarEn && (enVec & ~CEX_MASK) == '0 && skip == '0) |->
			($countones(claimed) == int'(cexCnt)))
		else $error("capture/compare pin count wrong");

	chk_latch_drive_low: assert property (@(posedge clk_sys) disable iff (rst)
		(xbarEn && !claimed[2] && !p0Latch_q[2]) |=> (pinOe[2] && !pinOut[2]))
		else $error("latch zero not driven low");

	chk_page_guard: assert property (@(posedge clk_sys) disable iff (rst)
		(sfrWe && !pageCfg && isAddr(sfrAddr, ADDR_ROUTE0)) |=> $stable(route0_q))
		else $error("route register written off its page");

	chk_clock_out_pin: assert property (@(posedge clk_sys) disable iff (rst)
		(xbarEn && enVec == (NUM_SIG'(1) << SIG_CLKOUT)) |->
			(claimed == 16'h0001) && (pinSel[0] == 5'(SIG_CLKOUT)))
		else $error("clock output not on first pin");

	chk_push_pull_high: assert property (@(posedge clk_sys) disable iff (rst)
		(xbarEn && !claimed[3] && p0Mode_q[3] && p0Latch_q[3]) |=> (pinOe[3] && pinOut[3]))
		else $error("push-pull latch one not driven high");

	chk_rx_mode0_drain: assert property (@(posedge clk_sys) disable iff (rst)
		(xbarEn && route0_q[B0_UARTA] && uartAMode0 && periphOe[SIG_RXA]) |=> !pinOut[1])
		else $error("mode-0 receive pin driven high");

	chk_p1_digital_read: assert property (@(posedge clk_sys) disable iff (rst)
		(sfrRe && isAddr(sfrAddr, ADDR_P1) && p1InMode_q[0]) |=> (sfrRdata[0] == $past(pinIn[8])))
		else $error("digital pin read differs from pin");
endmodule // pxc_crossbar

// File: pkg/pxc_pkg.sv
// constants for the port crossbar and port 0/1 configuration block
// Contract
// - counter-array field routes 0..6 capture/compare outputs
// - serial port A uses pins 0.0 and 0.1
// - SPI takes four pins, three without select
// - two-wire route places data and clock
// - reg0 routes comparator 0 and count input
// - reg1 bit 7 routes inverted clock output
// - reg1 bits 6..1 route timer and irq inputs, bit 0 routes comparator 1
// - reg2 bit 7 disables all weak pull-ups
// - crossbar disabled forces ports to input
// - reg2 bit 5 reads zero, ignores writes
// - reg2 routes timer 4 and serial port B
// - reg3 bit 7 sets CAN transmit drive mode
// - reg3 routes comparator 2, convert start, timer 3
// - latch drives unclaimed pins per drive mode
// - port data read returns pin level
// - drive mode bit: 0 open-drain, 1 push-pull
// - two-wire and mode-0 receive always open-drain
// - analog port 1 pin reads zero, no pull-up
// - digital port 1 pin reads pin, pull-up global
// - analog port 1 pins skipped by crossbar
// - port data on all pages, config on page F
package pxc_pkg;
	localparam int NUM_SIG = 32;
	localparam int NUM_PIN = 16;
	localparam logic [7:0] ADDR_P0 = 8'h80;
	localparam logic [7:0] ADDR_P1 = 8'h90;
	localparam logic [7:0] ADDR_P0MODE = 8'ha4;
	localparam logic [7:0] ADDR_P1MODE = 8'ha5;
	localparam logic [7:0] ADDR_P1INMODE = 8'had;
	localparam logic [7:0] ADDR_ROUTE0 = 8'he1;
	localparam logic [7:0] ADDR_ROUTE1 = 8'he2;
	localparam logic [7:0] ADDR_ROUTE2 = 8'he3;
	localparam logic [7:0] ADDR_ROUTE3 = 8'he4;
	localparam logic [7:0] PAGE_CFG = 8'h0f;
	localparam logic [7:0] RST_LATCH = 8'hff;
	localparam logic [7:0] RST_MODE = 8'h00;
	localparam logic [7:0] RST_INMODE = 8'hff;
	localparam logic [7:0] RST_ROUTE = 8'h00;
	localparam logic [7:0] ROUTE2_WMASK = 8'hdc;
	localparam logic [7:0] ROUTE3_WMASK = 8'h8f;
	localparam logic IDLE_IN = 1'b1;
	// route register bit positions
	localparam int B0_CP0 = 7;
	localparam int B0_ECI = 6;
	localparam int B0_CEX_HI = 5;
	localparam int B0_CEX_LO = 3;
	localparam int B0_UARTA = 2;
	localparam int B0_SPI = 1;
	localparam int B0_TWI = 0;
	localparam int B2_PUDIS = 7;
	localparam int B2_XBAR = 6;
	localparam int B2_T4EX = 4;
	localparam int B2_T4 = 3;
	localparam int B2_UARTB = 2;
	localparam int B3_CANPP = 7;
	localparam int B3_CP2 = 3;
	localparam int B3_CNV = 2;
	localparam int B3_T3EX = 1;
	localparam int B3_T3 = 0;
	localparam logic [2:0] CEX_MAX = 3'd6;
	// peripheral signal indices, in crossbar priority order
	localparam int SIG_TXA = 0;
	localparam int SIG_RXA = 1;
	localparam int SIG_SCK = 2;
	localparam int SIG_NSS = 5;
	localparam int SIG_SDA = 6;
	localparam int SIG_SCL = 7;
	localparam int SIG_TXB = 8;
	localparam int SIG_RXB = 9;
	localparam int SIG_CAPTURE_COMPARE_IO_ZERO = 10;
	localparam int SIG_ECI = 16;
	localparam int SIG_CP0 = 17;
	localparam int SIG_CP1 = 18;
	localparam int SIG_CP2 = 19;
	localparam int SIG_T0 = 20;
	localparam int SIG_T4EX = 29;
	localparam int SIG_CLKOUT = 30;
	localparam int SIG_CNV = 31;
	localparam logic [31:0] CEX_MASK = 32'h0000fc00;
endpackage

// File: verif/pxc_pin_model.sv
// board side of the port pins: device drive, outside driver, pull-up or floating
`timescale 1ns/1ps
module pxc_pin_model
	import pxc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic [NUM_PIN-1:0] pinOut,
	input wire logic [NUM_PIN-1:0] pinOe,
	input wire logic [NUM_PIN-1:0] pullupEn,
	input wire logic [NUM_PIN-1:0] extOe,
	input wire logic [NUM_PIN-1:0] extVal,
	output logic [NUM_PIN-1:0] pinIn
);
	// an undriven pin without pull-up wanders, so a stale level never passes for a real one
	logic [NUM_PIN-1:0] floatLvl_q = 16'h5a5a;
	always_ff @(posedge clk_sys) begin
		floatLvl_q <= ~floatLvl_q;
	end
	assign pinIn = (pinOe & pinOut) | (~pinOe & extOe & extVal)
		| (~pinOe & ~extOe & (pullupEn | floatLvl_q));
endmodule // pxc_pin_model

// File: verif/testbench.sv
// self-checking bench for the port crossbar
`timescale 1ns/1ps
module testbench;
	import pxc_pkg::*;
	typedef struct {int sel; logic [31:0] exp;} pxc_note_s;
	logic clk_sys = 1'b0, rst = 1'b1, sfrWe = 1'b0, sfrRe = 1'b0, sfrHit, canTxPushPull;
	logic bitWe = 1'b0, bitVal = 1'b0, spiFourWire = 1'b0, uartAMode0 = 1'b0, r;
	logic uartBMode0 = 1'b0;
	logic [7:0] sfrAddr = 8'h00, sfrPage = 8'h00, sfrWdata = 8'h00, bitAddr = 8'h00, sfrRdata;
	logic [31:0] periphOut = 32'h0, periphOe = 32'h0, periphIn, v;
	logic [15:0] extOe = 16'h0, extVal = 16'h0, pinIn, pinOut, pinOe, pullupEn;
	logic [55:0] e;
	int n_errors = 0, checks_done = 0, cycles = 0, seed = 32'h2bbc4aec, s;
	pxc_note_s notes[$], cur;
	// route0 route1 route2 route3 fourWire signal pin
	logic [55:0] tbl [11] = '{56'h80000000001100, 56'h82000000011104, 56'h82000000001103,
		56'h85000000001104, 56'h04000000000000, 56'h00010008001301, 56'h00800400001e02,
		56'h00801800001e02, 56'h0000000c001f01, 56'h00800003001e02, 56'h00800000001e00};
	pxc_crossbar pxc_crossbar_inst (.clk_sys(clk_sys), .rst(rst), .sfrAddr(sfrAddr),
		.sfrPage(sfrPage), .sfrWe(sfrWe), .sfrWdata(sfrWdata), .sfrRe(sfrRe),
		.sfrRdata(sfrRdata), .sfrHit(sfrHit), .bitWe(bitWe), .bitAddr(bitAddr),
		.bitVal(bitVal), .spiFourWire(spiFourWire), .uartAMode0(uartAMode0),
		.uartBMode0(uartBMode0), .periphOut(periphOut), .periphOe(periphOe), .periphIn(periphIn),
		.pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .pullupEn(pullupEn),
		.canTxPushPull(canTxPushPull));
	pxc_pin_model pxc_pin_model_inst (.clk_sys(clk_sys), .pinOut(pinOut), .pinOe(pinOe),
		.pullupEn(pullupEn), .extOe(extOe), .extVal(extVal), .pinIn(pinIn));
	initial forever #10 clk_sys = ~clk_sys;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic note(input int sel, input logic [31:0] exp);
		notes.push_back('{sel, exp});
		@(posedge clk_sys);
	endtask
	// registered outputs trail their cause by a cycle; two edges leave margin
	task automatic settle();
		repeat (2) @(posedge clk_sys);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
		@(posedge clk_sys);
		sfrAddr <= a;
		sfrPage <= p;
		sfrWdata <= d;
		sfrWe <= 1'b1;
		@(posedge clk_sys);
		sfrWe <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] p, input logic [8:0] x);
		@(posedge clk_sys);
		sfrAddr <= a;
		sfrPage <= p;
		sfrRe <= 1'b1;
		@(posedge clk_sys);
		sfrRe <= 1'b0;
		notes.push_back('{0, {23'h0, x}});
		@(posedge clk_sys);
	endtask
	always @(negedge clk_sys) begin
		if (notes.size() > 0) begin
			cur = notes.pop_front();
			case (cur.sel)
				0: check({23'h0, sfrHit, sfrRdata}, cur.exp);
				1: check({16'h0, pinOut}, cur.exp);
				2: check({16'h0, pinOe}, cur.exp);
				3: check({16'h0, pullupEn}, cur.exp);
				4: check(periphIn, cur.exp);
				default: check({31'h0, canTxPushPull}, cur.exp);
			endcase
		end
	end
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		settle();
		rd(ADDR_P0, 8'h00, 9'h1ff);
		rd(ADDR_P1, 8'h00, 9'h1ff);
		rd(ADDR_P0MODE, PAGE_CFG, 9'h100);
		rd(ADDR_P1MODE, PAGE_CFG, 9'h100);
		rd(ADDR_P1INMODE, PAGE_CFG, 9'h1ff);
		for (int i = 0; i < 4; i++) begin
			rd(ADDR_ROUTE0 + 8'(i), PAGE_CFG, 9'h100);
		end
		rd(ADDR_P0MODE, 8'h00, 9'h000);
		rd(8'h55, PAGE_CFG, 9'h000);
		wr(ADDR_ROUTE0, 8'h00, 8'hff);
		rd(ADDR_ROUTE0, PAGE_CFG, 9'h100);
		note(3, 32'hffff);
		wr(ADDR_ROUTE2, PAGE_CFG, 8'hbf);
		wr(ADDR_ROUTE3, PAGE_CFG, 8'hff);
		wr(ADDR_P0MODE, PAGE_CFG, 8'hff);
		wr(ADDR_P0, 8'h00, 8'h00);
		rd(ADDR_ROUTE2, PAGE_CFG, 9'h19c);
		rd(ADDR_ROUTE3, PAGE_CFG, 9'h18f);
		note(5, 32'h1);
		note(3, 32'h0);
		note(2, 32'h0);
		wr(ADDR_ROUTE3, PAGE_CFG, 8'h00);
		wr(ADDR_ROUTE2, PAGE_CFG, 8'h40);
		for (int k = 0; k < 4; k++) begin
			v = $random(seed);
			wr(ADDR_P0, v[15:8], v[7:0]);
			wr(ADDR_P0MODE, PAGE_CFG, k[0] ? 8'hff : 8'h00);
			settle();
			note(1, k[0] ? {24'h0, v[7:0]} : 32'h0);
			note(2, k[0] ? 32'hff : {24'h0, ~v[7:0]});
			rd(ADDR_P0, v[23:16], {1'b1, v[7:0]});
		end
		@(posedge clk_sys);
		bitAddr <= 8'h93;
		bitWe <= 1'b1;
		@(posedge clk_sys);
		bitWe <= 1'b0;
		wr(ADDR_P1INMODE, PAGE_CFG, 8'hf0);
		settle();
		note(2, 32'h08ff);
		note(3, {16'h0, 8'hf0, v[7:0]});
		rd(ADDR_P1, 8'h00, 9'h1f0);
		wr(ADDR_P1INMODE, PAGE_CFG, 8'hff);
		wr(ADDR_P1, 8'h00, 8'h00);
		// unclaimed port 0 pins must sit low so only routed signals show
		wr(ADDR_P0, 8'h00, 8'h00);
		wr(ADDR_P1MODE, PAGE_CFG, 8'hff);
		periphOe <= 32'hffffffff;
		periphOut <= CEX_MASK;
		for (int n = 0; n < 8; n++) begin
			wr(ADDR_ROUTE0, PAGE_CFG, 8'(n << 3));
			settle();
			note(1, (32'h1 << (n > 6 ? 6 : n)) - 32'h1);
		end
		for (int i = 0; i < 11; i++) begin
			e = tbl[i];
			spiFourWire <= e[16];
			periphOut <= 32'h1 << e[15:8];
			wr(ADDR_ROUTE0, PAGE_CFG, e[55:48]);
			wr(ADDR_ROUTE1, PAGE_CFG, e[47:40]);
			wr(ADDR_ROUTE2, PAGE_CFG, e[39:32] | 8'h40);
			wr(ADDR_ROUTE3, PAGE_CFG, e[31:24]);
			settle();
			note(1, 32'h1 << e[7:0]);
		end
		periphOe <= 32'h0;
		wr(ADDR_ROUTE3, PAGE_CFG, 8'h00);
		extOe <= 16'h0003;
		for (int b = 1; b < 8; b++) begin
			s = (b == 7) ? SIG_RXA : SIG_T0 - 1 + b;
			v = $random(seed);
			r = v[0];
			extVal <= {16{r}};
			wr(ADDR_ROUTE0, PAGE_CFG, (b == 7) ? 8'h04 : 8'h00);
			wr(ADDR_ROUTE1, PAGE_CFG, (b == 7) ? 8'h00 : 8'h01 << b);
			settle();
			// serial A claims both pins, so its transmit line reads its pin too
			v = (b == 7) ? {30'h3fffffff, r, r} : (~(32'h1 << s) | ({31'h0, r} << s));
			note(4, v);
		end
		periphOe <= 32'h202;
		periphOut <= 32'h202;
		uartAMode0 <= 1'b1;
		uartBMode0 <= 1'b1;
		extOe <= 16'h0;
		wr(ADDR_ROUTE2, PAGE_CFG, 8'h44);
		settle();
		note(2, 32'hfff0);
		periphOe <= 32'h40;
		periphOut <= 32'h40;
		wr(ADDR_ROUTE2, PAGE_CFG, 8'h40);
		wr(ADDR_ROUTE0, PAGE_CFG, 8'h01);
		settle();
		note(1, 32'h0);
		tally_and_finish();
	end
endmodule // testbench
